//--- rtl/adcr_pkg.sv
/*
 Constants for the converter result and data-line drive register bank.
 Assumes a byte-wide register port addressed by 8-bit offsets.
*/
package adcr_pkg;
   localparam logic [7:0] ADDR_SYS_RAIL = 8'h3d;
   localparam logic [7:0] ADDR_THERM = 8'h3f;
   localparam logic [7:0] ADDR_DIE_TEMP = 8'h41;
   localparam logic [7:0] ADDR_POS_LINE = 8'h43;
   localparam logic [7:0] ADDR_NEG_LINE = 8'h45;
   localparam logic [7:0] ADDR_DRIVE_CTRL = 8'h47;
   localparam logic [7:0] ADDR_PART_ID = 8'h48;
   localparam int RESULT_W = 16;
   localparam int NUM_RESULTS = 5;
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   localparam logic [7:0] DRIVE_CTRL_RESET = 8'h00;
   localparam int POS_SEL_LSB = 5;
   localparam int NEG_SEL_LSB = 2;
   localparam int RSVD_LSB = 0;
   localparam int SEL_W = 3;
   localparam int RSVD_W = 2;
   localparam int PN_LSB = 3;
   localparam int REV_LSB = 0;
   // Arbitrary neutral identity values
   localparam logic [2:0] PART_NUMBER_CODE = 3'h5;
   localparam logic [2:0] REVISION_CODE = 3'h2;
   localparam logic [2:0] NEG_SEL_RESERVED = 3'h7;
   localparam logic [2:0] SEL_HIGH_IMPEDANCE = 3'h0;
   localparam logic [2:0] POS_SEL_SHORT = 3'h7;
   localparam int STAGES = 3;
endpackage

//--- rtl/adcr_sync.sv
/*
 Three-stage synchroniser with a second/third stage agreement filter.
 Assumes the input is asynchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module adcr_sync #(
   parameter int W = 16
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   // Only s2/s3 are compared; s1 feeds s2 alone
   wire logic [W-1:0] agree = ~(s2 ^ s3);
   wire logic [W-1:0] next_out = (s2 & agree) | (sync_out & ~agree);
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         sync_out <= '0;
      end else begin
         s1 <= async_in;
         s2 <= s1;
         s3 <= s2;
         sync_out <= next_out;
      end
   end
endmodule
`default_nettype wire

//--- rtl/adcr_regs.sv
/*
 Converter result registers, data-line drive control and identification.
 Assumes results arrive from the converter asynchronously with a per-channel
 strobe level, and a simple byte register port on ref_clk.
*/
// How it works
// - System rail result at 0x3d, read-only 16 bits, 1 mV steps, resets zero.
// - Thermistor ratio at 0x3f, read-only 16 bits, resets zero.
// - Die temperature at 0x41, read-only two's complement, 0.5 C steps.
// - Positive data-line voltage at 0x43, read-only 16 bits, resets zero.
// - Negative data-line voltage at 0x45, read-only 16 bits, resets zero.
// - Bits 7..5 of drive register select positive line drive level.
// - Bits 4..2 select negative line drive; code 7 reserved.
// - Drive register at 0x47 resets zero; bits 1..0 reserved read-write.
// - Identification at 0x48: bits 7..6 zero, part number, revision.
`timescale 1ns/1ps
`default_nettype none
module adcr_regs (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata_lo,
   output logic [7:0] reg_rdata_hi,
   output logic reg_rvalid,
   input wire logic [15:0] system_rail_voltage_value,
   input wire logic [15:0] thermistor_ratio_value,
   input wire logic [15:0] die_temperature_value,
   input wire logic [15:0] positive_dataline_voltage_value,
   input wire logic [15:0] negative_dataline_voltage_value,
   input wire logic [4:0] result_load,
   output logic [2:0] positive_line_drive_select,
   output logic [2:0] negative_line_drive_select,
   output logic dataline_short,
   output logic positive_high_impedance,
   output logic negative_high_impedance
);
   localparam int RW = adcr_pkg::RESULT_W;
   localparam int NR = adcr_pkg::NUM_RESULTS;
   // Output reset levels follow from the drive register's own reset value
   localparam logic [2:0] RST_POS =
      adcr_pkg::DRIVE_CTRL_RESET[adcr_pkg::POS_SEL_LSB +: adcr_pkg::SEL_W];
   localparam logic [2:0] RST_NEG =
      adcr_pkg::DRIVE_CTRL_RESET[adcr_pkg::NEG_SEL_LSB +: adcr_pkg::SEL_W];
   localparam logic RST_SHORT = RST_POS == adcr_pkg::POS_SEL_SHORT;
   localparam logic RST_POS_HIZ = RST_POS == adcr_pkg::SEL_HIGH_IMPEDANCE;
   localparam logic RST_NEG_HIZ = (RST_NEG == adcr_pkg::SEL_HIGH_IMPEDANCE) |
      (RST_NEG == adcr_pkg::NEG_SEL_RESERVED);
   logic [RW-1:0] result_reg [NR];
   logic [7:0] dataline_drive_control;
   logic [RW-1:0] raw_in [NR];
   logic [RW-1:0] synced [NR];
   logic [NR-1:0] load_sync;
   logic [NR-1:0] load_prev;

   assign raw_in[0] = system_rail_voltage_value;
   assign raw_in[1] = thermistor_ratio_value;
   assign raw_in[2] = die_temperature_value;
   assign raw_in[3] = positive_dataline_voltage_value;
   assign raw_in[4] = negative_dataline_voltage_value;

   adcr_sync #(.W(NR)) u_load_sync (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .async_in(result_load),
      .sync_out(load_sync)
   );

   // Value captured on the rising edge of its synced strobe; data is stable
   // by then since it settled before the strobe.
   genvar g;
   generate
      for (g = 0; g < NR; g++) begin : g_res
         adcr_sync #(.W(RW)) u_data_sync (
            .ref_clk(ref_clk),
            .rst_b(rst_b),
            .async_in(raw_in[g]),
            .sync_out(synced[g])
         );
         wire logic take = load_sync[g] & ~load_prev[g];
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               result_reg[g] <= adcr_pkg::RESULT_RESET;
            end else if (take) begin
               result_reg[g] <= synced[g];
            end
         end
      end
   endgenerate

   // Reset low like an idle strobe, so release never fakes a capture
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         load_prev <= '0;
      end else begin
         load_prev <= load_sync;
      end
   end

   // Named views of the result registers
   wire logic [15:0] system_rail_voltage_result = result_reg[0];
   wire logic [15:0] thermistor_ratio_result = result_reg[1];
   wire logic [15:0] die_temperature_result = result_reg[2];
   wire logic [15:0] positive_dataline_voltage_result = result_reg[3];
   wire logic [15:0] negative_dataline_voltage_result = result_reg[4];

   // Address decode
   wire logic hit_sys_rail = reg_addr == adcr_pkg::ADDR_SYS_RAIL;
   wire logic hit_therm = reg_addr == adcr_pkg::ADDR_THERM;
   wire logic hit_die_temp = reg_addr == adcr_pkg::ADDR_DIE_TEMP;
   wire logic hit_pos_line = reg_addr == adcr_pkg::ADDR_POS_LINE;
   wire logic hit_neg_line = reg_addr == adcr_pkg::ADDR_NEG_LINE;
   wire logic hit_drive = reg_addr == adcr_pkg::ADDR_DRIVE_CTRL;
   wire logic hit_id = reg_addr == adcr_pkg::ADDR_PART_ID;
   // Only the drive register takes a write; other offsets drop it
   wire logic wr_drive = reg_wr & hit_drive;
   wire logic [2:0] wpos = reg_wdata[adcr_pkg::POS_SEL_LSB +: adcr_pkg::SEL_W];
   wire logic [2:0] wneg = reg_wdata[adcr_pkg::NEG_SEL_LSB +: adcr_pkg::SEL_W];
   wire logic [1:0] wrsvd = reg_wdata[adcr_pkg::RSVD_LSB +: adcr_pkg::RSVD_W];
   // Reserved negative code is stored as written; outputs treat it as off
   wire logic [7:0] next_drive = {wpos, wneg, wrsvd};
   wire logic [7:0] part_identification =
      {2'h0, adcr_pkg::PART_NUMBER_CODE, adcr_pkg::REVISION_CODE};

   // Unmapped offsets and upper bytes of byte registers read zero
   wire logic [15:0] drive_word = {8'h00, dataline_drive_control};
   wire logic [15:0] id_word = {8'h00, part_identification};
   wire logic [15:0] rd_word =
      hit_sys_rail ? system_rail_voltage_result :
      hit_therm ? thermistor_ratio_result :
      hit_die_temp ? die_temperature_result :
      hit_pos_line ? positive_dataline_voltage_result :
      hit_neg_line ? negative_dataline_voltage_result :
      hit_drive ? drive_word :
      hit_id ? id_word : 16'h0000;
   wire logic [7:0] rd_lo = rd_word[7:0];
   wire logic [7:0] rd_hi = rd_word[15:8];

   wire logic [2:0] cur_pos = dataline_drive_control[adcr_pkg::POS_SEL_LSB +: adcr_pkg::SEL_W];
   wire logic [2:0] cur_neg = dataline_drive_control[adcr_pkg::NEG_SEL_LSB +: adcr_pkg::SEL_W];
   wire logic next_short = cur_pos == adcr_pkg::POS_SEL_SHORT;
   wire logic next_pos_hiz = cur_pos == adcr_pkg::SEL_HIGH_IMPEDANCE;
   // Reserved negative code is held off rather than driven to a guess
   wire logic next_neg_hiz = (cur_neg == adcr_pkg::SEL_HIGH_IMPEDANCE) |
                             (cur_neg == adcr_pkg::NEG_SEL_RESERVED);

   // Holds the host's drive choice; only a write to its own offset moves it
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         dataline_drive_control <= adcr_pkg::DRIVE_CTRL_RESET;
      end else if (wr_drive) begin
         dataline_drive_control <= next_drive;
      end
   end

   // Every read strobe is answered one cycle later, mapped or not
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rvalid <= '0;
      end else begin
         reg_rvalid <= reg_rd;
      end
   end

   // Read data holds until the next read so a slow host can still take it
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata_lo <= '0;
      end else if (reg_rd) begin
         reg_rdata_lo <= rd_lo;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata_hi <= '0;
      end else if (reg_rd) begin
         reg_rdata_hi <= rd_hi;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         positive_line_drive_select <= RST_POS;
      end else begin
         positive_line_drive_select <= cur_pos;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         negative_line_drive_select <= RST_NEG;
      end else begin
         negative_line_drive_select <= cur_neg;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         dataline_short <= RST_SHORT;
      end else begin
         dataline_short <= next_short;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         positive_high_impedance <= RST_POS_HIZ;
      end else begin
         positive_high_impedance <= next_pos_hiz;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         negative_high_impedance <= RST_NEG_HIZ;
      end else begin
         negative_high_impedance <= next_neg_hiz;
      end
   end
endmodule
`default_nettype wire

//--- test/adcr_conv_model.sv
/* Converter stand-in driving result values and load strobes.
   Assumes the bench calls put() between register accesses. */
`timescale 1ns/1ps
`default_nettype none
module adcr_conv_model (
   output logic [15:0] val [5],
   output logic [4:0] load
);
   initial begin
      foreach (val[i]) val[i] = 16'h0000;
      load = 5'h00;
   end
   // Held across the sync window, then scrambled so stale data shows
   task automatic put(input int ch, input logic [15:0] x);
      val[ch] = x;
      #300 load[ch] = 1'b1;
      #1500 load[ch] = 1'b0;
      val[ch] = ~x;
   endtask
endmodule
`default_nettype wire

//--- test/adcr_regs_chk.sv
/* Assertions on the register port and drive outputs.
   Assumes binding to adcr_regs. */
`timescale 1ns/1ps
`default_nettype none
module adcr_regs_chk (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata_lo,
   input wire logic [7:0] reg_rdata_hi,
   input wire logic reg_rvalid,
   input wire logic [2:0] positive_line_drive_select,
   input wire logic [2:0] negative_line_drive_select,
   input wire logic dataline_short,
   input wire logic positive_high_impedance,
   input wire logic negative_high_impedance
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   chk_read_answer: assert property (reg_rd |=> reg_rvalid)
      else $error("no read answer");
   chk_id_value: assert property (reg_rd && reg_addr == 8'h48 |=>
      {reg_rdata_hi, reg_rdata_lo} == {10'h0, adcr_pkg::PART_NUMBER_CODE,
      adcr_pkg::REVISION_CODE}) else $error("bad id");
   chk_ctrl_high: assert property (reg_rd && reg_addr == 8'h47 |=> !reg_rdata_hi)
      else $error("drive read high byte");
   chk_pos_write: assert property (reg_wr && reg_addr == 8'h47 |-> ##2
      positive_line_drive_select == $past(reg_wdata[7:5], 2)) else $error("pos select");
   chk_neg_write: assert property (reg_wr && reg_addr == 8'h47 |-> ##2
      negative_line_drive_select == $past(reg_wdata[4:2], 2)) else $error("neg select");
   chk_line_short: assert property (
      dataline_short == (positive_line_drive_select == 3'h7)) else $error("short flag");
   chk_pos_hiz: assert property (
      positive_high_impedance == !positive_line_drive_select) else $error("pos hiz");
   chk_neg_hiz: assert property (negative_high_impedance ==
      (negative_line_drive_select inside {3'h0, 3'h7})) else $error("neg hiz");
   cover property (reg_rd && reg_addr == 8'h48);
   cover property (dataline_short);
   cover property (reg_wr && reg_addr == 8'h3d);
   cover property (negative_line_drive_select == 3'h7 && negative_high_impedance);
endmodule
bind adcr_regs adcr_regs_chk chk_u (.ref_clk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
   .reg_rdata_lo, .reg_rdata_hi, .reg_rvalid, .positive_line_drive_select,
   .negative_line_drive_select, .dataline_short, .positive_high_impedance,
   .negative_high_impedance);
`default_nettype wire

//--- test/adcr_regs_test.sv
/* Self-checking bench for adcr_regs.
   Assumes adcr_pkg and the converter model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module adcr_regs_test;
   logic ref_clk, rst_b, reg_wr, reg_rd, rv, sh, phz, nhz;
   logic [7:0] reg_addr, reg_wdata, lo, hi;
   logic [15:0] val [5];
   logic [4:0] load;
   logic [2:0] ps, ns;
   int n_errors, samples_checked;
   localparam logic [15:0] ID_WORD = {10'h0, adcr_pkg::PART_NUMBER_CODE, adcr_pkg::REVISION_CODE};
   adcr_regs dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_lo(lo), .reg_rdata_hi(hi),
      .reg_rvalid(rv), .system_rail_voltage_value(val[0]), .thermistor_ratio_value(val[1]),
      .die_temperature_value(val[2]), .positive_dataline_voltage_value(val[3]),
      .negative_dataline_voltage_value(val[4]), .result_load(load),
      .positive_line_drive_select(ps), .negative_line_drive_select(ns),
      .dataline_short(sh), .positive_high_impedance(phz), .negative_high_impedance(nhz));
   adcr_conv_model conv_u (.val(val), .load(load));
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   task automatic check(input string what, input logic [15:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge ref_clk) #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge ref_clk) #1;
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] q);
      int i;
      @(posedge ref_clk) #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge ref_clk) #1;
      reg_rd = 1'b0;
      for (i = 0; i < 4 && rv !== 1'b1; i++) @(posedge ref_clk) #1;
      if (i == 4) begin
         n_errors++;
         complete_run();
      end else begin
         q = {hi, lo};
      end
   endtask
   // Sweep includes the unmapped gaps, which must read zero
   task automatic t_reset;
      logic [15:0] q;
      logic [15:0] e;
      for (int a = 8'h3d; a <= 8'h48; a++) begin
         rd(8'(a), q);
         e = (a == 8'h48) ? ID_WORD : 16'h0000;
         check("reset rd", q, e);
      end
      check("reset drive", {ps, ns, sh, phz, nhz}, 16'h0003);
   endtask
   task automatic t_results;
      logic [15:0] q;
      logic [15:0] v [5] = '{16'h5dc0, 16'h03ff, 16'hffb0, 16'h0e10, 16'h0001};
      for (int c = 0; c < 5; c++) begin
         conv_u.put(c, v[c]);
         wr(8'h3d + 8'(2 * c), 8'h5a);
         rd(8'h3d + 8'(2 * c), q);
         check("result", q, v[c]);
      end
   endtask
   task automatic t_drive;
      logic [15:0] q;
      for (int c = 0; c < 8; c++) begin
         wr(8'h47, {3'(c), 3'(7 - c), 2'(c)});
         wr(8'h48, 8'hff);
         rd(8'h47, q);
         check("drive reg", q, {8'h00, 3'(c), 3'(7 - c), 2'(c)});
         check("drive out", {ps, ns, sh, phz, nhz},
            {3'(c), 3'(7 - c), c == 7, c == 0, c == 0 || c == 7});
      end
      rd(8'h48, q);
      check("id", q, ID_WORD);
   endtask
   initial begin
      rst_b = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      n_errors = 0;
      samples_checked = 0;
      repeat (16) @(posedge ref_clk);
      #1 rst_b = 1'b1;
      t_reset();
      t_results();
      t_drive();
      rst_b = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 rst_b = 1'b1;
      t_reset();
      complete_run();
   end
endmodule
`default_nettype wire
